/* rtl/pgd_cfg.svh */
// constants for the gain and power-down mode decoder: control register
// layout, reset values and the power-down and gain codes.
// assumes it is included by bare name from each design file.
`ifndef PGD_CFG_SVH
`define PGD_CFG_SVH

// -----------------------------------------------------------------------
// control register layout
// -----------------------------------------------------------------------
`define PGD_CTRL_W      12
`define PGD_CTRL_RST    12'h000
`define PGD_CAL_BIT     7
`define PGD_PD_MSB      6
`define PGD_PD_LSB      4
`define PGD_GN_MSB      3
`define PGD_GN_LSB      0

// -----------------------------------------------------------------------
// gain codes and values
// -----------------------------------------------------------------------
`define PGD_GAIN_W      8
`define PGD_GAIN_DEF    8'h01
`define PGD_GAIN_NONE   8'h00
`define PGD_GN_SOFT     4'h0
`define PGD_GN_RSVD     4'hF

// -----------------------------------------------------------------------
// power-down codes
// -----------------------------------------------------------------------
`define PGD_PD_ALL_OFF  3'h0
`define PGD_PD_ADC      3'h1
`define PGD_PD_CD       3'h2
`define PGD_PD_AB       3'h3
`define PGD_PD_CMP      3'h4
`define PGD_PD_ALL_ON   3'h5
`define PGD_PD_RESET    3'h7

`endif

/* rtl/pgd_pkg.sv */
// types shared by the gain and power-down mode decoder.
// assumes pgd_cfg.svh supplies the numeric constants.
package pgd_pkg;

  // -----------------------------------------------------------------------
  // field types
  // -----------------------------------------------------------------------
  typedef logic [3:0]  pgd_gain_code_t;
  typedef logic [2:0]  pgd_pd_code_t;
  typedef logic [7:0]  pgd_gain_t;
  typedef logic [11:0] pgd_ctrl_t;

  // -----------------------------------------------------------------------
  // operating state
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PGD_ST_REG,
    PGD_ST_PIN,
    PGD_ST_PIN_RST
  } pgd_state_t;

endpackage

/* rtl/pgd_gain_dec.sv */
// gain decoder: maps a 4-bit gain code onto the amplifier gain.
// assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
`include "pgd_cfg.svh"

module pgd_gain_dec (
  // code in
  input  pgd_pkg::pgd_gain_code_t code,
  input  logic                    reg_mode,
  // decoded gain
  output pgd_pkg::pgd_gain_t      gain,
  output logic                    reserved
);
  import pgd_pkg::*;

  // -----------------------------------------------------------------------
  // gain table
  // -----------------------------------------------------------------------
  function automatic pgd_gain_t pgd_gain_of(input pgd_gain_code_t c);
    case (c)
      4'h1:    pgd_gain_of = 8'h01; // RQ3
      4'h2:    pgd_gain_of = 8'h02; // RQ3
      4'h3:    pgd_gain_of = 8'h03; // RQ3
      4'h4:    pgd_gain_of = 8'h04; // RQ3
      4'h5:    pgd_gain_of = 8'h06; // RQ3
      4'h6:    pgd_gain_of = 8'h08; // RQ3
      4'h7:    pgd_gain_of = 8'h0C; // RQ3
      4'h8:    pgd_gain_of = 8'h10; // RQ4
      4'h9:    pgd_gain_of = 8'h18; // RQ4
      4'hA:    pgd_gain_of = 8'h20; // RQ4
      4'hB:    pgd_gain_of = 8'h30; // RQ4
      4'hC:    pgd_gain_of = 8'h40; // RQ4
      4'hD:    pgd_gain_of = 8'h60; // RQ4
      4'hE:    pgd_gain_of = 8'h80; // RQ4
      default: pgd_gain_of = `PGD_GAIN_NONE;
    endcase
  endfunction

  // register code zero means the power-up default gain of one
  assign gain     = (reg_mode && code == `PGD_GN_SOFT) ? `PGD_GAIN_DEF // RQ13
                                                       : pgd_gain_of(code);
  assign reserved = (code == `PGD_GN_RSVD); // RQ5

endmodule // pgd_gain_dec

/* rtl/pgd_pwr_dec.sv */
// power-down decoder: maps a 3-bit code onto comparator pair and
// converter enables. assumes the caller registers the result.
`timescale 1ns/1ps
`include "pgd_cfg.svh"

module pgd_pwr_dec (
  // code in
  input  pgd_pkg::pgd_pd_code_t code,
  // enables out
  output logic                  cmp_ab_en,
  output logic                  cmp_cd_en,
  output logic                  adc_en,
  output logic                  reset_code
);
  import pgd_pkg::*;

  // -----------------------------------------------------------------------
  // power table, result is {ab, cd, adc}
  // -----------------------------------------------------------------------
  function automatic logic [2:0] pgd_pd_map(input pgd_pd_code_t c);
    case (c)
      `PGD_PD_ALL_OFF: pgd_pd_map = 3'h0; // RQ8
      `PGD_PD_ADC:     pgd_pd_map = 3'h1; // RQ9
      `PGD_PD_CD:      pgd_pd_map = 3'h2; // RQ9
      `PGD_PD_AB:      pgd_pd_map = 3'h4; // RQ9
      `PGD_PD_CMP:     pgd_pd_map = 3'h6; // RQ9
      `PGD_PD_ALL_ON:  pgd_pd_map = 3'h7; // RQ8
      // 111 and the undefined 110 keep everything off
      default:         pgd_pd_map = 3'h0; // RQ10
    endcase
  endfunction

  // unpack the enables
  assign {cmp_ab_en, cmp_cd_en, adc_en} = pgd_pd_map(code);
  assign reset_code = (code == `PGD_PD_RESET);

endmodule // pgd_pwr_dec

/* rtl/pgd_mode_top.sv */
// gain and power-down mode decoder top: picks pin or register control,
// holds the control register, registers all enables and the gain.
// assumes all pins and the register write port are synchronous to
// core_clk; the serial framing of register writes lives elsewhere.
//
// How it works
// [RQ1] any gain pin high selects pin-driven operation
// [RQ2] all gain pins low: gain comes from the control register
// [RQ3] codes 0001..0111 give gains 1, 2, 3, 4, 6, 8, 12
// [RQ4] codes 1000..1110 give gains 16 to 128, fourteen gains total
// [RQ5] code 1111 is reserved; driver avoids it, gain is held
// [RQ6] pin mode takes reference and calibration start from pins
// [RQ7] power code from pins in pin mode, else from the register
// [RQ8] code 000 turns all off, code 101 turns all on
// [RQ9] codes 001, 010, 011, 100 enable converters, CD, AB, all comparators
// [RQ10] code 111 resets the device in pin mode only, all off
// [RQ11] that reset clears registers, leaves comparators and converters off
// [RQ12] register bit 7 calibrates, bits 6:4 power code, 3:0 gain
// [RQ13] register mode after power-up: all off, gain one until written
`timescale 1ns/1ps
`include "pgd_cfg.svh"

module pgd_mode_top (
  // clock and control
  input  logic                    core_clk,
  input  logic                    rst,
  input  logic                    clk_en,
  // configuration pins
  input  pgd_pkg::pgd_gain_code_t gain_select_pins,
  input  pgd_pkg::pgd_pd_code_t   power_down_code_pins,
  input  logic                    reference_select_pin,
  input  logic                    cal_pin,
  // control register write port
  input  logic                    ctrl_wr_stb,
  input  pgd_pkg::pgd_ctrl_t      ctrl_wr_data,
  // mode and readback
  output pgd_pkg::pgd_state_t     state_q,
  output logic                    pin_mode_q,
  output logic                    dev_reset_q,
  output pgd_pkg::pgd_ctrl_t      ctrl_reg_q,
  // gain
  output pgd_pkg::pgd_gain_code_t gain_code_q,
  output pgd_pkg::pgd_gain_t      gain_value_q,
  output logic                    gain_reserved_q,
  // power and reference
  output logic                    cmp_ab_en_q,
  output logic                    cmp_cd_en_q,
  output logic                    adc_en_q,
  output logic                    int_ref_sel_q,
  // calibration
  output logic                    cal_start_q
);
  import pgd_pkg::*;

  // -----------------------------------------------------------------------
  // mode selection
  // -----------------------------------------------------------------------
  logic           pin_mode_d;
  logic           pin_reset_d;
  pgd_state_t     state_d;
  pgd_ctrl_t      ctrl_reg_d;
  pgd_gain_code_t eff_gain_code;
  pgd_pd_code_t   eff_pd_code;
  logic           eff_cal;
  logic           cal_prev_q;
  logic           cal_start_d;
  pgd_gain_t      dec_gain;
  logic           dec_rsvd;
  logic           dec_ab;
  logic           dec_cd;
  logic           dec_adc;
  logic           dec_rst_code;

  // any high gain pin means the pins own the configuration
  assign pin_mode_d  = (gain_select_pins != `PGD_GN_SOFT); // RQ1
  // the all-ones power code resets only when the pins are in charge
  assign pin_reset_d = pin_mode_d && dec_rst_code; // RQ10

  // next state from the current pins
  always_comb begin
    if (pin_reset_d) begin
      state_d = PGD_ST_PIN_RST;
    end else if (pin_mode_d) begin
      state_d = PGD_ST_PIN;
    end else begin
      state_d = PGD_ST_REG;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= PGD_ST_REG;
    end else if (clk_en) begin
      case (state_d)
        PGD_ST_REG:     state_q <= PGD_ST_REG;
        PGD_ST_PIN:     state_q <= PGD_ST_PIN;
        PGD_ST_PIN_RST: state_q <= PGD_ST_PIN_RST;
        default:        state_q <= PGD_ST_REG;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------------
  // writes only land in register mode: in pin mode the serial data pin
  // doubles as a power-down pin, so anything seen there is not a write
  always_comb begin
    ctrl_reg_d = ctrl_reg_q;
    if (pin_reset_d) begin
      ctrl_reg_d = `PGD_CTRL_RST; // RQ11
    end else if (!pin_mode_d && ctrl_wr_stb) begin
      ctrl_reg_d = ctrl_wr_data; // RQ12
    end
  end

  // register storage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg_q <= `PGD_CTRL_RST; // RQ13
    end else if (clk_en) begin
      ctrl_reg_q <= ctrl_reg_d;
    end
  end

  // -----------------------------------------------------------------------
  // source selection and decoders
  // -----------------------------------------------------------------------
  // next register value is used so a write acts on the same edge that stores it
  assign eff_gain_code = pin_mode_d ? gain_select_pins // RQ2
                       : ctrl_reg_d[`PGD_GN_MSB:`PGD_GN_LSB];
  assign eff_pd_code   = pin_mode_d ? power_down_code_pins // RQ7
                       : ctrl_reg_d[`PGD_PD_MSB:`PGD_PD_LSB];
  assign eff_cal       = pin_mode_d ? cal_pin // RQ6
                       : ctrl_reg_d[`PGD_CAL_BIT];

  pgd_gain_dec u_gain (
    .code     (eff_gain_code),
    .reg_mode (!pin_mode_d),
    .gain     (dec_gain),
    .reserved (dec_rsvd)
  );

  pgd_pwr_dec u_pwr (
    .code       (eff_pd_code),
    .cmp_ab_en  (dec_ab),
    .cmp_cd_en  (dec_cd),
    .adc_en     (dec_adc),
    .reset_code (dec_rst_code)
  );

  // -----------------------------------------------------------------------
  // mode outputs
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_mode_q  <= 1'b0;
      dev_reset_q <= 1'b0;
    end else if (clk_en) begin
      pin_mode_q  <= pin_mode_d; // RQ1
      dev_reset_q <= pin_reset_d; // RQ10
    end
  end

  // -----------------------------------------------------------------------
  // gain outputs
  // -----------------------------------------------------------------------
  // a reserved code keeps the last good gain rather than a bogus one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gain_code_q     <= `PGD_GN_SOFT;
      gain_value_q    <= `PGD_GAIN_DEF;
      gain_reserved_q <= 1'b0;
    end else if (clk_en) begin
      gain_reserved_q <= dec_rsvd; // RQ5
      if (!dec_rsvd) begin
        gain_code_q  <= eff_gain_code; // RQ2
        gain_value_q <= dec_gain; // RQ3
      end
    end
  end

  // -----------------------------------------------------------------------
  // power and reference outputs
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmp_ab_en_q <= 1'b0;
      cmp_cd_en_q <= 1'b0;
      adc_en_q    <= 1'b0;
    end else if (clk_en) begin
      cmp_ab_en_q <= dec_ab && !pin_reset_d; // RQ11
      cmp_cd_en_q <= dec_cd && !pin_reset_d; // RQ11
      adc_en_q    <= dec_adc && !pin_reset_d; // RQ8
    end
  end

  // the reference pin is a strap and is honoured in both modes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_ref_sel_q <= 1'b0;
    end else if (clk_en) begin
      int_ref_sel_q <= reference_select_pin; // RQ6
    end
  end

  // -----------------------------------------------------------------------
  // calibration start
  // -----------------------------------------------------------------------
  // a rising level starts one calibration; a held level does not repeat
  assign cal_start_d = eff_cal && !cal_prev_q && !pin_reset_d; // RQ6

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cal_prev_q  <= 1'b0;
      cal_start_q <= 1'b0;
    end else if (clk_en) begin
      cal_prev_q  <= eff_cal && !pin_reset_d; // RQ11
      cal_start_q <= cal_start_d; // RQ12
    end
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  chk_pin_mode_sel: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins != 4'h0
      |=> pin_mode_q && (state_q != PGD_ST_REG)) // RQ1
    else $error("pin mode not entered with a gain pin high");

  chk_reg_gain_src: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins == 4'h0 && !ctrl_wr_stb
      && ctrl_reg_q[3:0] != 4'hF
      |=> !pin_mode_q && gain_code_q == $past(ctrl_reg_q[3:0])) // RQ2
    else $error("register gain not applied in register mode");

  chk_gain_low_tab: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins == 4'h7 |=> gain_value_q == 8'h0C) // RQ3
    else $error("gain code 0111 not twelve");

  chk_gain_high_tab: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins == 4'hE |=> gain_value_q == 8'h80) // RQ4
    else $error("gain code 1110 not 128");

  chk_gain_rsvd_hold: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins == 4'hF
      |=> gain_reserved_q && $stable(gain_value_q)) // RQ5
    else $error("reserved gain code changed the gain");

  chk_cal_pin_edge: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins != 4'h0 && power_down_code_pins != 3'h7
      && cal_pin && !cal_prev_q |=> cal_start_q ##1 !cal_start_q
      || !clk_en) // RQ6
    else $error("calibrate pin edge gave no single pulse");

  chk_pd_pin_src: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins != 4'h0 && power_down_code_pins == 3'h1
      |=> adc_en_q && !cmp_ab_en_q && !cmp_cd_en_q) // RQ7
    else $error("pin power code 001 not applied");

  chk_pd_all_on: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && eff_pd_code == 3'h5
      |=> adc_en_q && cmp_ab_en_q && cmp_cd_en_q) // RQ8
    else $error("power code 101 did not enable everything");

  chk_pd_cd_only: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && eff_pd_code == 3'h2
      |=> cmp_cd_en_q && !cmp_ab_en_q && !adc_en_q) // RQ9
    else $error("power code 010 not comparators C and D only");

  chk_pin_reset_off: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins != 4'h0 && power_down_code_pins == 3'h7
      |=> dev_reset_q && ctrl_reg_q == 12'h000
      && !adc_en_q && !cmp_ab_en_q && !cmp_cd_en_q) // RQ11
    else $error("pin reset did not clear and power down");

  chk_reg_no_reset: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins == 4'h0 |=> !dev_reset_q) // RQ10
    else $error("reset taken outside pin mode");

  chk_ctrl_write: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins == 4'h0 && ctrl_wr_stb
      |=> ctrl_reg_q == $past(ctrl_wr_data)
      && adc_en_q == ($past(ctrl_wr_data[6:4]) inside {3'h1, 3'h5})) // RQ12
    else $error("control register write not applied");

  chk_powerup_dflt: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && gain_select_pins == 4'h0 && !ctrl_wr_stb
      && ctrl_reg_q == 12'h000
      |=> gain_value_q == 8'h01 && !adc_en_q && !cmp_ab_en_q) // RQ13
    else $error("register mode default not gain one and off");

  cov_pin_reset: cover property (@(posedge core_clk) disable iff (rst)
    !dev_reset_q ##1 dev_reset_q ##1 !dev_reset_q);

  cov_reg_write: cover property (@(posedge core_clk) disable iff (rst)
    !pin_mode_q && ctrl_wr_stb ##1 adc_en_q);

  cov_cal_start: cover property (@(posedge core_clk) disable iff (rst)
    cal_start_q);

  cov_mode_swap: cover property (@(posedge core_clk) disable iff (rst)
    pin_mode_q ##1 !pin_mode_q);

endmodule // pgd_mode_top

/* testbench/pgd_host_model.sv */
// host controller and board strapping model for the mode decoder.
// assumes the bench calls its tasks; inputs change at falling edges.
`timescale 1ns/1ps

module pgd_host_model (
  // clock
  input  logic                    core_clk,
  // configuration pins
  output pgd_pkg::pgd_gain_code_t gain_select_pins,
  output pgd_pkg::pgd_pd_code_t   power_down_code_pins,
  output logic                    reference_select_pin,
  output logic                    cal_pin,
  // control register write port
  output logic                    ctrl_wr_stb,
  output pgd_pkg::pgd_ctrl_t      ctrl_wr_data
);
  // -----------------------------------------------------------------------
  // idle levels at time zero
  // -----------------------------------------------------------------------
  initial begin
    gain_select_pins     = 4'h0;
    power_down_code_pins = 3'h0;
    reference_select_pin = 1'b0;
    cal_pin              = 1'b0;
    ctrl_wr_stb          = 1'b0;
    ctrl_wr_data         = 12'h000;
  end

  // strap pins, then wait one edge so the outputs have answered
  task automatic set_pins(input logic [3:0] g, input logic [2:0] pd,
                          input logic r, input logic c,
                          input logic rsvd_ok);
    @(negedge core_clk);
    // a real strapping never offers the undefined code unless told to
    gain_select_pins     = (g == 4'hF && !rsvd_ok) ? 4'hE : g;
    power_down_code_pins = pd;
    reference_select_pin = r;
    cal_pin              = c;
    @(negedge core_clk);
  endtask

  // one-cycle strobe; data goes to the inverse once released
  task automatic write_reg(input logic [11:0] d);
    @(negedge core_clk);
    ctrl_wr_stb  = 1'b1;
    ctrl_wr_data = d;
    @(negedge core_clk);
    ctrl_wr_stb  = 1'b0;
    ctrl_wr_data = ~d;
  endtask
endmodule // pgd_host_model

/* testbench/pgd_mode_top_tb_top.sv */
// self-checking bench for the gain and power-down mode decoder.
// assumes pgd_host_model drives all pins; clk_en and rst come from here.
`timescale 1ns/1ps
`include "pgd_cfg.svh"

module pgd_mode_top_tb_top;
  import pgd_pkg::*;
  // -----------------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------------
  logic            core_clk, rst, clk_en, ref_pin, cal_pin, wr_stb;
  logic            pin_mode_q, dev_reset_q, gain_reserved_q, cal_start_q;
  logic            cmp_ab_en_q, cmp_cd_en_q, adc_en_q, int_ref_sel_q;
  pgd_gain_code_t  gain_pins, gain_code_q;
  pgd_pd_code_t    pd_pins;
  pgd_ctrl_t       wr_data, ctrl_reg_q;
  pgd_gain_t       gain_value_q;
  pgd_state_t      state_q;
  logic [2:0]      en;
  logic [31:0]     seed;
  logic [11:0]     d;
  int              errors, cmp_count;

  assign en = {cmp_ab_en_q, cmp_cd_en_q, adc_en_q};

  pgd_mode_top u_pgd_mode_top (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .gain_select_pins(gain_pins), .power_down_code_pins(pd_pins),
    .reference_select_pin(ref_pin), .cal_pin(cal_pin),
    .ctrl_wr_stb(wr_stb), .ctrl_wr_data(wr_data),
    .state_q(state_q), .pin_mode_q(pin_mode_q),
    .dev_reset_q(dev_reset_q), .ctrl_reg_q(ctrl_reg_q),
    .gain_code_q(gain_code_q), .gain_value_q(gain_value_q),
    .gain_reserved_q(gain_reserved_q), .cmp_ab_en_q(cmp_ab_en_q),
    .cmp_cd_en_q(cmp_cd_en_q), .adc_en_q(adc_en_q),
    .int_ref_sel_q(int_ref_sel_q), .cal_start_q(cal_start_q));

  pgd_host_model u_pgd_host_model (
    .core_clk(core_clk), .gain_select_pins(gain_pins),
    .power_down_code_pins(pd_pins), .reference_select_pin(ref_pin),
    .cal_pin(cal_pin), .ctrl_wr_stb(wr_stb), .ctrl_wr_data(wr_data));

  // -----------------------------------------------------------------------
  // expectation helpers
  // -----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // code 0 falls back to the power-up gain of one
  function automatic logic [7:0] exp_gain(input logic [3:0] c);
    logic [7:0] t [16];
    t = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0C,
          8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'h01};
    return t[c];
  endfunction

  // order is {pair A B, pair C D, converters}
  function automatic logic [2:0] exp_en(input logic [2:0] c);
    logic [2:0] t [8];
    t = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h0, 3'h0};
    return t[c];
  endfunction

  task automatic check(input string nm, input logic [11:0] exp,
                       input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------------
  // clock and watchdog
  // -----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // tests take well under 300 cycles, so this only trips on a hang
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    test_done();
  end

  // -----------------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    seed = 32'h5CD6;
    errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    @(negedge core_clk);
    check("gain", `PGD_GAIN_DEF, gain_value_q);
    check("en", 3'h0, en);
    check("state", PGD_ST_REG, state_q);
    $display("test reset done");
    // gain codes 1 to 14, power codes 0 to 6, random reference strap
    for (int g = 1; g < 15; g++) begin
      d = 12'(rnd());
      u_pgd_host_model.set_pins(g[3:0], 3'(g % 7), d[0], 1'b0, 1'b0);
      check("pin_mode", 1'b1, pin_mode_q);
      check("state", PGD_ST_PIN, state_q);
      check("gain_code", g[3:0], gain_code_q);
      if (g < 8) check("gain", exp_gain(g[3:0]), gain_value_q);
      else check("gain", exp_gain(g[3:0]), gain_value_q);
      check("en", exp_en(3'(g % 7)), en);
      check("ref", d[0], int_ref_sel_q);
    end
    $display("test pin decode done");
    // pins say 111 in register mode: no reset, pins ignored
    u_pgd_host_model.set_pins(4'h0, 3'h7, 1'b1, 1'b0, 1'b0);
    check("dev_reset", 1'b0, dev_reset_q);
    for (int i = 0; i < 16; i++) begin
      d = 12'(rnd());
      d = {d[11:8], 1'b0, 3'(i % 8), 4'(d[7:4] % 15)};
      u_pgd_host_model.write_reg(d);
      check("ctrl", d, ctrl_reg_q);
      check("gain", exp_gain(d[3:0]), gain_value_q);
      check("gain_code", d[3:0], gain_code_q);
      check("en", exp_en(d[6:4]), en);
      check("dev_reset", 1'b0, dev_reset_q);
    end
    $display("test register decode done");
    u_pgd_host_model.write_reg(12'h080);
    check("cal", 1'b1, cal_start_q);
    @(negedge core_clk);
    check("cal", 1'b0, cal_start_q);
    u_pgd_host_model.write_reg(12'h051);
    u_pgd_host_model.set_pins(4'h3, 3'h5, 1'b0, 1'b0, 1'b0);
    u_pgd_host_model.set_pins(4'h3, 3'h5, 1'b0, 1'b1, 1'b0);
    check("cal", 1'b1, cal_start_q);
    @(negedge core_clk);
    check("cal", 1'b0, cal_start_q);
    $display("test calibration done");
    // write refused in pin mode, then the undefined gain code
    u_pgd_host_model.write_reg(12'h0D3);
    check("ctrl", 12'h051, ctrl_reg_q);
    u_pgd_host_model.set_pins(4'hF, 3'h5, 1'b0, 1'b1, 1'b1);
    check("gain", 8'h03, gain_value_q);
    check("gain_code", 4'h3, gain_code_q);
    check("rsvd", 1'b1, gain_reserved_q);
    $display("test refusal done");
    // pin reset clears the register and powers all down
    u_pgd_host_model.set_pins(4'h2, 3'h7, 1'b0, 1'b0, 1'b0);
    check("dev_reset", 1'b1, dev_reset_q);
    check("state", PGD_ST_PIN_RST, state_q);
    check("en", 3'h0, en);
    check("ctrl", `PGD_CTRL_RST, ctrl_reg_q);
    u_pgd_host_model.set_pins(4'h0, 3'h5, 1'b0, 1'b0, 1'b0);
    check("gain", 8'h01, gain_value_q);
    check("en", 3'h0, en);
    $display("test pin reset done");
    // frozen while the enable is low, then catches up
    clk_en = 1'b0;
    u_pgd_host_model.set_pins(4'h5, 3'h5, 1'b0, 1'b0, 1'b0);
    check("pin_mode", 1'b0, pin_mode_q);
    clk_en = 1'b1;
    @(negedge core_clk);
    check("gain", 8'h06, gain_value_q);
    check("en", 3'h7, en);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    check("state", PGD_ST_REG, state_q);
    check("en", 3'h0, en);
    @(negedge core_clk);
    check("pin_mode", 1'b1, pin_mode_q);
    $display("test enable and reset done");
    test_done();
  end
endmodule // pgd_mode_top_tb_top
